// ### core/wim_pkg.sv
// Purpose: Constants and types for the wake input monitor.
// Assumes: core_clk at 10 MHz.
// Notes: Holds field encodings, filter times and mode codes.
//
// Overview of operation
// RULE1: Every wake pin signals on both rising and falling threshold crossings.
// RULE2: Qualified edge gives interrupt in run/stop, wake-up in sleep/safe.
// RULE3: Static mode watches always; cyclic mode only inside the timer window.
// RULE4: Crossing starts filter; wake only if no new crossing before it ends.
// RULE5: Each pin's wake ability is enabled individually by software.
// RULE6: A pin wake sets that pin's flag in the first status register.
// RULE7: Level bits report live level in run/stop, sampled level in cyclic.
// RULE8: Alternate output pins as wake inputs use short filter, second status.
// RULE9: Pull field: 00 none, 01 pull-down, 10 pull-up, 11 automatic.
// RULE10: Automatic pull enables pull-up when high, pull-down when low.
// RULE11: Filter field: short static, long static, cyclic timer one or two.
// RULE12: Software assigns the cyclic timer to a high-side supply output.
// RULE13: Measurement off at reset; switch closes only in run mode.
// RULE14: Measurement kills pulls on pins one and two and gates them.
// RULE15: Measurement freezes status and level bits of pins one and two.
// RULE16: Sleep request with only pins one/two enabled fails to restart; code refuses it only while measurement is enabled.
// RULE17: Wake interrupt only for enabled pins; level bits never interrupt.
// RULE18: Filters are oscillator counters restarted by every crossing.
// RULE19: Wake flags stay set until software clears them.
package wim_pkg;
   localparam int CLK_MHZ = 10;
   localparam int SHORT_FILTER_US = 16;
   localparam int LONG_FILTER_US = 64;
   localparam int SHORT_FILTER_CYC = SHORT_FILTER_US * CLK_MHZ;
   localparam int LONG_FILTER_CYC = LONG_FILTER_US * CLK_MHZ;
   localparam int CNT_W = 10;
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP = 2'h2;
   localparam logic [1:0] PULL_AUTO = 2'h3;
   localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
   localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
   localparam logic [1:0] FLT_CYCLIC_ONE = 2'h2;
   localparam logic [1:0] FLT_CYCLIC_TWO = 2'h3;
   localparam logic [2:0] MODE_ACTIVE_RUN = 3'h0;
   localparam logic [2:0] MODE_LOW_POWER_STOP = 3'h1;
   localparam logic [2:0] MODE_DEEP_SLEEP = 3'h2;
   localparam logic [2:0] MODE_SAFE_STATE = 3'h3;
   localparam logic [2:0] MODE_RESTART = 3'h4;
endpackage

// ### core/wim_edge_filter.sv
// Purpose: One glitch filter channel for a wake input.
// Assumes: Input already synchronous to core_clk.
// Notes: Pulses qualified once the new level stood for the full interval.
`timescale 1ns/1ps
module wim_edge_filter
   import wim_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sampleEn,
   input wire logic longSel,
   input wire logic pinIn,
   output logic qualPulse,
   output logic stableLevel
);
   logic lastIn_r, lastIn_nxt;
   logic stable_r, stable_nxt;
   logic busy_r, busy_nxt;
   logic pulse_r, pulse_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [CNT_W-1:0] limit;

   assign limit = longSel ? CNT_W'(LONG_FILTER_CYC - 1) :
                            CNT_W'(SHORT_FILTER_CYC - 1);
   assign qualPulse = pulse_r;
   assign stableLevel = stable_r;

   always_comb begin
      lastIn_nxt = lastIn_r;
      stable_nxt = stable_r;
      busy_nxt = busy_r;
      pulse_nxt = 1'b0;
      cnt_nxt = cnt_r;
      if (!sampleEn) begin
         // Outside the sense window no crossing can be seen. The half-seen
         // level is forgotten, so the next window meets it as a crossing.
         lastIn_nxt = stable_r;
         busy_nxt = 1'b0; // [RULE3]
         cnt_nxt = '0;
      end else if (pinIn != lastIn_r) begin
         lastIn_nxt = pinIn;
         busy_nxt = (pinIn != stable_r); // [RULE4]
         cnt_nxt = '0; // [RULE18]
      end else if (busy_r) begin
         if (cnt_r >= limit) begin
            busy_nxt = 1'b0;
            stable_nxt = lastIn_r;
            pulse_nxt = 1'b1; // [RULE1]
         end else begin
            cnt_nxt = cnt_r + CNT_W'(1); // [RULE18]
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         lastIn_r <= 1'b0;
         stable_r <= 1'b0;
         busy_r <= 1'b0;
         pulse_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         lastIn_r <= lastIn_nxt;
         stable_r <= stable_nxt;
         busy_r <= busy_nxt;
         pulse_r <= pulse_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// ### core/wim_wake_monitor.sv
// Purpose: Wake input monitor for three wake pins and two alternate pins.
// Assumes: All inputs synchronous to core_clk; control bits from SPI.
// Notes: Flags clear by one-cycle clear strobes; a new event wins.
`timescale 1ns/1ps
module wim_wake_monitor
   import wim_pkg::*;
#(
   parameter int NUM_PINS = 3,
   parameter int NUM_ALT = 2
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [NUM_PINS-1:0] wakePin,
   input wire logic [NUM_ALT-1:0] altPinIn,
   input wire logic [NUM_ALT-1:0] altWakeEnable,
   input wire logic [NUM_PINS-1:0] wakeEnable,
   input wire logic [2*NUM_PINS-1:0] pullSelect,
   input wire logic [2*NUM_PINS-1:0] filterSelect,
   input wire logic measurementEnable,
   input wire logic [2:0] devMode,
   input wire logic cyclicWindowOne,
   input wire logic cyclicWindowTwo,
   input wire logic sleepRequest,
   input wire logic [NUM_PINS-1:0] statusFirstClear,
   input wire logic [NUM_ALT-1:0] statusSecondClear,
   output logic [NUM_PINS-1:0] wakeStatusFirst,
   output logic [NUM_ALT-1:0] wakeStatusSecond,
   output logic [NUM_PINS-1:0] pinLevel,
   output logic [NUM_PINS-1:0] pullUpEn,
   output logic [NUM_PINS-1:0] pullDownEn,
   output logic measurementSwitch,
   output logic wakeIrqPulse,
   output logic wakeUpPulse,
   output logic cmdFailFlag,
   output logic restartReq
);
   // -----------------------------------------------------------------
   // Filters
   // -----------------------------------------------------------------
   logic [NUM_PINS-1:0] qual, stable, gated, sampleEn, rawIn;
   logic [NUM_ALT-1:0] altQual;
   logic measActive;

   function automatic logic isMeasPin(input int idx);
      return idx < 2;
   endfunction

   assign measActive = measurementEnable;

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : gPin
         logic [1:0] flt;
         assign flt = filterSelect[2*g +: 2];
         // Pins one and two are gated off while measuring.
         assign gated[g] = measActive && isMeasPin(g); // [RULE14]
         assign rawIn[g] = gated[g] ? 1'b0 : wakePin[g];
         always_comb begin
            case (flt)
               FLT_CYCLIC_ONE: sampleEn[g] = cyclicWindowOne; // [RULE3]
               FLT_CYCLIC_TWO: sampleEn[g] = cyclicWindowTwo; // [RULE11]
               default: sampleEn[g] = 1'b1;
            endcase
         end
         wim_edge_filter uFilt (
            .core_clk(core_clk),
            .rstn(rstn),
            .sampleEn(sampleEn[g] && !gated[g]),
            .longSel(flt == FLT_STATIC_LONG), // [RULE11]
            .pinIn(rawIn[g]),
            .qualPulse(qual[g]),
            .stableLevel(stable[g])
         );
      end
      for (g = 0; g < NUM_ALT; g++) begin : gAlt
         // Alternate pins always run the short static filter.
         wim_edge_filter uAltFilt (
            .core_clk(core_clk),
            .rstn(rstn),
            .sampleEn(altWakeEnable[g]),
            .longSel(1'b0), // [RULE8]
            .pinIn(altPinIn[g]),
            .qualPulse(altQual[g]),
            .stableLevel()
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // Status, level and pull state
   // -----------------------------------------------------------------
   logic [NUM_PINS-1:0] stat1_r, stat1_nxt, lvl_r, lvl_nxt;
   logic [NUM_PINS-1:0] pu_r, pu_nxt, pd_r, pd_nxt;
   logic [NUM_ALT-1:0] stat2_r, stat2_nxt;
   logic sw_r, sw_nxt, irq_r, irq_nxt, wu_r, wu_nxt;
   logic fail_r, fail_nxt, rst_r, rst_nxt;
   logic [NUM_PINS-1:0] ev;
   logic [NUM_ALT-1:0] altEv;
   logic runStop, sleepSafe, onlyMeasPins;

   // -----------------------------------------------------------------
   // Mode and wake source decode
   // -----------------------------------------------------------------
   // Both pulses look at the same event set, so it is decoded once.
   function automatic logic anyWake(input logic [NUM_PINS-1:0] p,
                                    input logic [NUM_ALT-1:0] a);
      return (p != '0) || (a != '0);
   endfunction

   assign runStop = (devMode == MODE_ACTIVE_RUN) ||
                    (devMode == MODE_LOW_POWER_STOP);
   assign sleepSafe = (devMode == MODE_DEEP_SLEEP) ||
                      (devMode == MODE_SAFE_STATE);
   assign ev = qual & wakeEnable & ~gated; // [RULE5] [RULE15]
   assign altEv = altQual & altWakeEnable;
   // The refusal counts the alternate pins as wake sources as well.
   assign onlyMeasPins = (wakeEnable[1:0] != 2'h0) &&
                         (wakeEnable[NUM_PINS-1:2] == '0) &&
                         (altWakeEnable == '0);

   // -----------------------------------------------------------------
   // Flag, level and pull next state
   // -----------------------------------------------------------------
   always_comb begin
      stat1_nxt = stat1_r;
      stat2_nxt = stat2_r;
      lvl_nxt = lvl_r;
      pu_nxt = '0;
      pd_nxt = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         // Set wins over a clear in the same cycle.
         if (ev[i]) begin
            stat1_nxt[i] = 1'b1; // [RULE6]
         end else if (statusFirstClear[i]) begin
            stat1_nxt[i] = 1'b0; // [RULE19]
         end
         if (runStop && !gated[i]) begin // [RULE15]
            // Cyclic pins show the level seen in the last window.
            lvl_nxt[i] = (filterSelect[2*i+1]) ? stable[i]
                                               : wakePin[i]; // [RULE7]
         end
         if (!gated[i]) begin // [RULE14]
            case (pullSelect[2*i +: 2])
               PULL_DOWN: pd_nxt[i] = 1'b1; // [RULE9]
               PULL_UP: pu_nxt[i] = 1'b1;
               PULL_AUTO: begin
                  pu_nxt[i] = wakePin[i]; // [RULE10]
                  pd_nxt[i] = !wakePin[i];
               end
               default: ;
            endcase
         end
      end
      for (int j = 0; j < NUM_ALT; j++) begin
         if (altEv[j]) begin
            stat2_nxt[j] = 1'b1; // [RULE8]
         end else if (statusSecondClear[j]) begin
            stat2_nxt[j] = 1'b0; // [RULE19]
         end
      end
   end

   // -----------------------------------------------------------------
   // Events, measurement switch and sleep check
   // -----------------------------------------------------------------
   always_comb begin
      sw_nxt = measurementEnable && (devMode == MODE_ACTIVE_RUN); // [RULE13]
      irq_nxt = runStop && anyWake(ev, altEv); // [RULE17]
      wu_nxt = sleepSafe && anyWake(ev, altEv); // [RULE2]
      // A refused sleep command is answered by a one-cycle restart request;
      // the failure flag stays set until the next reset.
      fail_nxt = fail_r;
      rst_nxt = 1'b0;
      if (sleepRequest && measActive && onlyMeasPins) begin
         fail_nxt = 1'b1; // [RULE16]
         rst_nxt = 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         stat1_r <= '0;
         stat2_r <= '0;
         lvl_r <= '0;
         pu_r <= '0;
         pd_r <= '0;
         sw_r <= 1'b0;
         irq_r <= 1'b0;
         wu_r <= 1'b0;
         fail_r <= 1'b0;
         rst_r <= 1'b0;
      end else begin
         stat1_r <= stat1_nxt;
         stat2_r <= stat2_nxt;
         lvl_r <= lvl_nxt;
         pu_r <= pu_nxt;
         pd_r <= pd_nxt;
         sw_r <= sw_nxt;
         irq_r <= irq_nxt;
         wu_r <= wu_nxt;
         fail_r <= fail_nxt;
         rst_r <= rst_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign wakeStatusFirst = stat1_r;
   assign wakeStatusSecond = stat2_r;
   assign pinLevel = lvl_r;
   assign pullUpEn = pu_r;
   assign pullDownEn = pd_r;
   assign measurementSwitch = sw_r;
   assign wakeIrqPulse = irq_r;
   assign wakeUpPulse = wu_r;
   assign cmdFailFlag = fail_r;
   assign restartReq = rst_r;
endmodule

// ### tb/wim_checker.sv
// Purpose: Port-level assertions for the wake input monitor.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Pin three is used for pull checks; it never feels measurement.
`timescale 1ns/1ps
module wim_checker
   import wim_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [1:0] altWakeEnable,
   input wire logic [2:0] wakeEnable,
   input wire logic [5:0] pullSelect,
   input wire logic measurementEnable,
   input wire logic [2:0] devMode,
   input wire logic sleepRequest,
   input wire logic [2:0] statusFirstClear,
   input wire logic [2:0] wakeStatusFirst,
   input wire logic [2:0] pullUpEn,
   input wire logic [2:0] pullDownEn,
   input wire logic measurementSwitch,
   input wire logic wakeIrqPulse,
   input wire logic wakeUpPulse,
   input wire logic cmdFailFlag,
   input wire logic restartReq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   chk_switch_run: assert property (
      $past(rstn) |-> measurementSwitch == ($past(measurementEnable) &&
      $past(devMode) == MODE_ACTIVE_RUN)) else $error("switch state wrong");
   chk_meas_pulls: assert property (
      $past(rstn) && $past(measurementEnable) |-> (pullUpEn[1:0] |
      pullDownEn[1:0]) == 2'h0) else $error("pull on while measuring");
   chk_pull_fixed: assert property (
      $past(rstn) && $past(pullSelect[5:4]) != PULL_AUTO |-> {pullUpEn[2],
      pullDownEn[2]} == $past(pullSelect[5:4])) else $error("pull wrong");
   chk_flag_hold: assert property (
      $past(rstn) |-> ($past(wakeStatusFirst) & ~wakeStatusFirst &
      ~$past(statusFirstClear)) == 3'h0) else $error("flag lost");
   chk_fail_sticky: assert property (
      $past(rstn) && $past(cmdFailFlag) |-> cmdFailFlag)
      else $error("fail flag lost");
   chk_sleep_fail: assert property (
      sleepRequest && measurementEnable && wakeEnable[2] == 1'h0 &&
      wakeEnable[1:0] != 2'h0 && altWakeEnable == 2'h0 |=> restartReq &&
      cmdFailFlag ##1 !restartReq) else $error("sleep fail missed");
   chk_irq_mode: assert property (
      wakeIrqPulse |-> $past(devMode) == MODE_ACTIVE_RUN ||
      $past(devMode) == MODE_LOW_POWER_STOP) else $error("irq mode wrong");
   chk_wakeup_mode: assert property (
      wakeUpPulse |-> $past(devMode) == MODE_DEEP_SLEEP ||
      $past(devMode) == MODE_SAFE_STATE) else $error("wake mode wrong");
   cover property (wakeUpPulse);
   cover property (restartReq);
   cover property (measurementSwitch ##1 !measurementSwitch);
endmodule
bind wim_wake_monitor wim_checker i_chk (.*);

// ### tb/wim_pin_model.sv
// Purpose: Switches and sense circuits sitting on the wake pins.
// Assumes: The bench moves drive and level 10 ns after the edge.
// Notes: A released pin with no pull wanders every cycle.
`timescale 1ns/1ps
module wim_pin_model (
   input wire logic core_clk,
   input wire logic [2:0] drive,
   input wire logic [2:0] level,
   input wire logic [2:0] pullUpEn,
   input wire logic [2:0] pullDownEn,
   output logic [2:0] wakePin
);
   logic [2:0] wander = 3'h0;
   // A floating pin must not settle on a value the simulator picks.
   always @(negedge core_clk) wander <= ~wander;
   // A pin is driven only while its sense circuit is supplied.
   always_comb
      for (int i = 0; i < 3; i++)
         wakePin[i] = drive[i] ? level[i] :
            (pullUpEn[i] ^ pullDownEn[i]) ? pullUpEn[i] : wander[i];
endmodule

// ### tb/wim_wake_monitor_bench.sv
// Purpose: Self-checking bench for the wake input monitor.
// Assumes: Inputs move 10 ns after each rising clock edge.
// Notes: Alternate pins get one scenario; cyclic filters get four, over both windows.
`timescale 1ns/1ps
module wim_wake_monitor_bench
   import wim_pkg::*;
;
   logic core_clk = 1'h0, rstn = 1'h0, measurementEnable = 1'h0;
   logic sleepRequest = 1'h0, measurementSwitch, cmdFailFlag, restartReq;
   logic [2:0] wakeEnable = 3'h0, drive = 3'h7, level = 3'h0, devMode = 3'h0;
   logic [2:0] statusFirstClear = 3'h0, wakePin, wakeStatusFirst, pinLevel;
   logic [5:0] pullSelect = 6'h00, filterSelect = 6'h00;
   logic [2:0] pullUpEn, pullDownEn;
   logic wakeIrqPulse, wakeUpPulse;
   logic cyclicWindowOne = 1'h0, cyclicWindowTwo = 1'h0;
   logic [1:0] altPinIn = 2'h0, altWakeEnable = 2'h0, wakeStatusSecond;
   logic [1:0] statusSecondClear = 2'h0;
   logic [7:0] want, seen;
   logic [7:0] expQ[$];
   int nFail = 0, nTests = 0, seed = 52, i, k, g;
   wire [7:0] note = {1'h0, wakeStatusSecond, wakeIrqPulse, wakeUpPulse,
      wakeStatusFirst};
   always #50 core_clk = ~core_clk;
   wim_pin_model i_pins (.core_clk, .drive, .level, .pullUpEn, .pullDownEn,
      .wakePin);
   wim_wake_monitor i_dut (.core_clk, .rstn, .wakePin, .wakeEnable,
      .altPinIn, .altWakeEnable, .statusSecondClear,
      .cyclicWindowOne, .cyclicWindowTwo, .pullSelect,
      .filterSelect, .measurementEnable, .devMode, .sleepRequest,
      .statusFirstClear, .wakeStatusFirst, .wakeStatusSecond, .pinLevel,
      .pullUpEn, .pullDownEn, .measurementSwitch, .wakeIrqPulse,
      .wakeUpPulse, .cmdFailFlag, .restartReq);
   task automatic check(input logic [7:0] got, input logic [7:0] wnt);
      nTests++;
      if (got !== wnt) begin
         nFail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, got, wnt);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #10;
   endtask
   // An event with nothing expected compares against zero and so fails.
   function automatic logic [7:0] oldest();
      return expQ.size() > 0 ? expQ.pop_front() : 8'h00;
   endfunction
   task automatic drain(input int lim);
      for (k = 0; k < lim && expQ.size() > 0; k++)
         tick(1);
      if (expQ.size() > 0) begin
         nFail++;
         $display("unexpected at %0t: wake event missing", $time);
         summarize();
      end
   endtask
   // Pulses last one cycle, so the falling edge sees each exactly once.
   always @(negedge core_clk)
      if (rstn && (wakeIrqPulse || wakeUpPulse))
         check(note, oldest());
   initial begin
      tick(5);
      check(8'({measurementSwitch, cmdFailFlag}), 8'h00);
      rstn = 1'h1;
      wakeEnable = 3'h4;
      for (i = 0; i < 4; i++) begin
         devMode = 3'(i);
         filterSelect[5:4] = {1'h0, i[1]};
         g = 1 + {$random(seed)} % 150;
         level[2] = ~level[2];
         tick(g);
         level[2] = ~level[2];
         tick(5);
         level[2] = ~level[2];
         expQ.push_back(i < 2 ? 8'h14 : 8'h0c);
         tick(i[1] ? LONG_FILTER_CYC - 2 : SHORT_FILTER_CYC - 2);
         check(8'(wakeStatusFirst), 8'h00);
         drain(20);
         tick(30);
         want = {4'h0, level[2] | i[1], 3'h4};
         check(8'({pinLevel[2] | i[1], wakeStatusFirst}), want);
         statusFirstClear = 3'h4;
         tick(1);
         statusFirstClear = 3'h0;
         tick(1);
         check(8'(wakeStatusFirst), 8'h00);
      end
      devMode = MODE_ACTIVE_RUN;
      filterSelect[5:4] = FLT_CYCLIC_ONE;
      level[2] = ~level[2];
      tick(200);
      check(8'(wakeStatusFirst), 8'h00);
      level[2] = ~level[2];
      tick(5);
      filterSelect = 6'h00;
      wakeEnable = 3'h0;
      level[2] = ~level[2];
      tick(200);
      want = {4'h0, level[2], 3'h0};
      check(8'({pinLevel[2], wakeStatusFirst}), want);
      wakeEnable = 3'h4;
      filterSelect[5:4] = FLT_CYCLIC_TWO;
      level[2] = 1'h0;
      cyclicWindowOne = 1'h1;
      tick(200);
      cyclicWindowOne = 1'h0;
      drive[2] = 1'h0;
      tick(20);
      check(8'(wakeStatusFirst), 8'h00);
      g = 1 + {$random(seed)} % 150;
      cyclicWindowTwo = 1'h1;
      drive[2] = 1'h1;
      tick(g);
      cyclicWindowTwo = 1'h0;
      drive[2] = 1'h0;
      tick(20);
      check(8'(wakeStatusFirst), 8'h00);
      cyclicWindowTwo = 1'h1;
      drive[2] = 1'h1;
      expQ.push_back(8'h14);
      drain(200);
      cyclicWindowTwo = 1'h0;
      drive[2] = 1'h0;
      tick(2);
      check(8'({pinLevel[2], wakeStatusFirst}), 8'h04);
      statusFirstClear = 3'h4;
      drive[2] = 1'h1;
      tick(1);
      statusFirstClear = 3'h0;
      altWakeEnable = 2'h1;
      tick(2);
      altPinIn[0] = 1'h1;
      expQ.push_back(8'h30);
      tick(SHORT_FILTER_CYC - 2);
      check(8'(wakeStatusSecond), 8'h00);
      drain(20);
      statusSecondClear = 2'h1;
      tick(1);
      statusSecondClear = 2'h0;
      altWakeEnable = 2'h0;
      tick(1);
      check(8'({wakeStatusSecond, wakeStatusFirst}), 8'h00);
      for (i = 0; i < 4; i++) begin
         pullSelect[5:4] = 2'(i);
         want = i == 3 ? 8'({level[2], ~level[2]}) : 8'(i);
         tick(2);
         check(8'({pullUpEn[2], pullDownEn[2]}), want);
      end
      wakeEnable = 3'h3;
      measurementEnable = 1'h1;
      tick(2);
      pullSelect[3:0] = 4'ha;
      // Ungated, pins one and two would now show high and raise flags.
      level[1:0] = 2'h3;
      tick(300);
      seen = 8'({measurementSwitch, pullUpEn[1:0] | pullDownEn[1:0]});
      check(seen, 8'h04);
      check(8'({pinLevel[1:0], wakeStatusFirst[1:0]}), 8'h00);
      devMode = MODE_LOW_POWER_STOP;
      sleepRequest = 1'h1;
      tick(1);
      sleepRequest = 1'h0;
      seen = 8'({measurementSwitch, cmdFailFlag, restartReq});
      check(seen, 8'h03);
      tick(1);
      check(8'({cmdFailFlag, restartReq}), 8'h02);
      summarize();
   end
endmodule
